// *** shared/ovfco_pkg.sv ***
// Constants for the overvoltage fault and current offset command logic.
// Assumes a decoded command port (one command code per access) and a 50 MHz clock.
`default_nettype none
package ovfco_pkg;
   // Command codes
   localparam logic [7:0]  CMD_OFFSET     = 8'h39;
   localparam logic [7:0]  CMD_OV_LIMIT   = 8'h40;
   localparam logic [7:0]  CMD_OV_ACTION  = 8'h41;
   // Offset register layout
   localparam logic [4:0]  OFFSET_EXP     = 5'h1E;     // Exponent -2, 0.25 A step
   localparam int          OFFSET_MAN_W   = 4;
   localparam int          OFFSET_EXT_W   = 7;
   // Limit register layout
   localparam int          LIMIT_W        = 11;
   localparam logic [10:0] LIMIT_BRK_16   = 11'h248;   // 584
   localparam logic [10:0] LIMIT_BRK_20   = 11'h25C;   // 604
   localparam logic [10:0] LIMIT_BRK_50   = 11'h29A;   // 666
   localparam logic [7:0]  PCT_12         = 8'h0C;
   localparam logic [7:0]  PCT_16         = 8'h10;
   localparam logic [7:0]  PCT_20         = 8'h14;
   localparam logic [7:0]  PCT_50         = 8'h32;
   localparam logic [7:0]  PCT_FULL       = 8'h64;     // 100 percent
   // Action register layout
   localparam int          ACT_IGNORE_BIT = 7;
   localparam int          ACT_RETRY_LSB  = 3;
   localparam logic [2:0]  RETRY_LATCH    = 3'h0;
   localparam logic [2:0]  RETRY_AUTO     = 3'h7;
   localparam logic        ACT_IGNORE_RST = 1'b1;
   // Restart delay
   localparam int          CLK_HZ         = 50_000_000;
   localparam int          RESTART_MS     = 52;
   localparam int          RESTART_CYC    = (CLK_HZ / 1000) * RESTART_MS;
   localparam int          DELAY_CNT_W    = 22;
   // Sense widths
   localparam int          VOUT_W         = 12;
   localparam int          IOUT_W         = 12;
   // Response states
   typedef enum logic [1:0] {
      OVFCO_RUN     = 2'b00,
      OVFCO_LATCHED = 2'b01,
      OVFCO_WAIT    = 2'b10,
      OVFCO_IDLE    = 2'b11
   } ovfco_state_t;
endpackage : ovfco_pkg
`default_nettype wire

// *** tb/ovfco_checker.sv ***
// Checker for ovfco_top: read layouts, refused writes and fault flags.
// Assumes it is bound to ovfco_top, one clock and an async active-low reset.
`default_nettype none
module ovfco_checker (
   // Clock, reset and requests
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        cmd_wr,
   input wire logic        cmd_rd,
   input wire logic [7:0]  cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic        nvm_load,
   input wire logic        fixed_ov_threshold_select,
   input wire logic        fixed_ov_trip,
   // Answers and status
   input wire logic [15:0] cmd_rdata_r,
   input wire logic        cmd_rvalid_r,
   input wire logic        invalid_data_r,
   input wire logic        output_enable_r,
   input wire logic        overvoltage_fault_flag_r,
   input wire logic        output_fault_summary_flag_r,
   input wire logic        vout_status_ov_flag_r,
   input wire logic        smbalert_n_r
);
   // One domain, so clock and disable are given once
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////
   a_read_answer: assert property (cmd_rd |=> cmd_rvalid_r)
      else $error("read strobe not answered");
   a_no_stray: assert property (!cmd_rd |=> !cmd_rvalid_r)
      else $error("read answer without request");
   a_offset_layout: assert property (cmd_rd && cmd_code == ovfco_pkg::CMD_OFFSET |=>
      cmd_rdata_r[15:11] == ovfco_pkg::OFFSET_EXP && cmd_rdata_r[10:4] == {7{cmd_rdata_r[3]}})
      else $error("offset read layout wrong");
   a_limit_upper: assert property (cmd_rd && cmd_code == ovfco_pkg::CMD_OV_LIMIT |=>
      cmd_rdata_r[15:11] == 5'h0_0) else $error("limit upper bits not zero");
   a_action_fixed: assert property (cmd_rd && cmd_code == ovfco_pkg::CMD_OV_ACTION |=>
      cmd_rdata_r[15:8] == 8'h00 && !cmd_rdata_r[6] && cmd_rdata_r[2:0] == cmd_rdata_r[5:3])
      else $error("action read layout wrong");
   a_retry_refused: assert property (cmd_wr && !nvm_load && cmd_code == ovfco_pkg::CMD_OV_ACTION
      && !(cmd_wdata[5:3] inside {3'h0, 3'h7}) |=> invalid_data_r) else $error("bad retry not flagged");
   a_fixed_trip: assert property (fixed_ov_threshold_select && fixed_ov_trip
      |=> overvoltage_fault_flag_r) else $error("fixed trip not flagged");
   a_flags_agree: assert property (output_fault_summary_flag_r == overvoltage_fault_flag_r
      && vout_status_ov_flag_r == overvoltage_fault_flag_r && smbalert_n_r != overvoltage_fault_flag_r)
      else $error("status flags or alert disagree");
   // Main scenarios reached
   c_refused: cover property (invalid_data_r);
   c_fault: cover property ($rose(overvoltage_fault_flag_r));
   c_shutdown: cover property ($fell(output_enable_r));
endmodule : ovfco_checker
bind ovfco_top ovfco_checker i_ovfco_checker (.clk(clk), .rst_n(rst_n), .cmd_wr(cmd_wr),
   .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .nvm_load(nvm_load),
   .fixed_ov_threshold_select(fixed_ov_threshold_select), .fixed_ov_trip(fixed_ov_trip),
   .cmd_rdata_r(cmd_rdata_r), .cmd_rvalid_r(cmd_rvalid_r), .invalid_data_r(invalid_data_r),
   .output_enable_r(output_enable_r), .overvoltage_fault_flag_r(overvoltage_fault_flag_r),
   .output_fault_summary_flag_r(output_fault_summary_flag_r),
   .vout_status_ov_flag_r(vout_status_ov_flag_r), .smbalert_n_r(smbalert_n_r));
`default_nettype wire

// *** tb/ovfco_host.sv ***
// Host model: issues command strobes on the decoded command port.
// Assumes requests start after reset release; one command per strobe.
`default_nettype none
module ovfco_host (
   // Clock
   input  wire logic        clk,
   // Requests
   output logic             cmd_wr,
   output logic             cmd_rd,
   output logic [7:0]       cmd_code,
   output logic [15:0]      cmd_wdata,
   output logic             clear_faults,
   // Answers
   input  wire logic [15:0] cmd_rdata_r,
   input  wire logic        cmd_rvalid_r
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus at time zero
   initial begin
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
      clear_faults = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Write: strobe held over exactly one sampling edge
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge clk);
      #1 cmd_code = c;
      cmd_wdata = d;
      cmd_wr = 1'b1;
      @(posedge clk);
      #1 cmd_wr = 1'b0;
   endtask : wr
   // Read: bounded wait for the answer pulse, X if it never comes
   task automatic rd(input logic [7:0] c, output logic [15:0] q);
      q = 16'hxxxx;
      @(posedge clk);
      #1 cmd_code = c;
      cmd_rd = 1'b1;
      @(posedge clk);
      #1 cmd_rd = 1'b0;
      for (int n = 0; n < 4; n++) begin
         if (cmd_rvalid_r === 1'b1) begin
            q = cmd_rdata_r;
            break;
         end
         @(posedge clk);
         #1;
      end
   endtask : rd
   // Clear-faults command pulse
   task automatic clr();
      @(posedge clk);
      #1 clear_faults = 1'b1;
      @(posedge clk);
      #1 clear_faults = 1'b0;
   endtask : clr
endmodule : ovfco_host
`default_nettype wire

// *** tb/ovfco_top_bench.sv ***
// Self-checking bench for ovfco_top, driven through the host model.
// Assumes a 50 MHz clock and a shortened restart delay.
`default_nettype none
module ovfco_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int RC = 10;   // Short restart delay keeps the run brief
   logic clk, rst_n, cmd_wr, cmd_rd, clear_faults, cmd_rvalid_r, invalid_data_r, nvm_load, retry_store;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, cmd_rdata_r;
   logic [11:0] iout, iout_rep, sense_pos, sense_gnd, vcmd;
   logic ss_done, fix_sel, fix_trip, en_pin, oe, ovf, output_fault_summary_flag, vst, alert_n;
   logic nvm_bit = 1'b1;   // Restored retry bit, varied late in the run
   int fails = 0, total_checks = 0, cycles = 0;
   int lim [6] = '{583, 584, 603, 604, 665, 666};
   int pct [6] = '{12, 16, 16, 20, 20, 50};
   logic [3:0] man [4] = '{4'h8, 4'h8, 4'h7, 4'hF};
   int meas [4] = '{5, 20, 20, 0};
   int exp_i [4] = '{0, 12, 27, 0};
   ovfco_top #(.RESTART_CYC(RC)) i_ovfco_top (.clk(clk), .rst_n(rst_n), .cmd_wr(cmd_wr),
      .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .clear_faults(clear_faults),
      .cmd_rdata_r(cmd_rdata_r), .cmd_rvalid_r(cmd_rvalid_r), .invalid_data_r(invalid_data_r),
      .nvm_load(nvm_load), .nvm_offset_mantissa(4'h9), .nvm_ov_limit(11'h258),
      .nvm_ov_act_not_ignore(1'b1), .nvm_ov_retry_bit(nvm_bit), .nvm_ov_retry_store_r(retry_store),
      .iout_measured(iout), .iout_report_r(iout_rep), .output_sense_positive(sense_pos),
      .output_sense_ground(sense_gnd), .vout_commanded(vcmd), .softstart_done(ss_done),
      .fixed_ov_threshold_select(fix_sel), .fixed_ov_trip(fix_trip), .en_pin(en_pin),
      .output_enable_r(oe), .overvoltage_fault_flag_r(ovf), .output_fault_summary_flag_r(output_fault_summary_flag),
      .vout_status_ov_flag_r(vst), .smbalert_n_r(alert_n));
   ovfco_host i_ovfco_host (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .clear_faults(clear_faults), .cmd_rdata_r(cmd_rdata_r),
      .cmd_rvalid_r(cmd_rvalid_r));
   ////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         $display("CHECK FAILED timeout exp finished got hung");
         complete_run();
      end
   end
   // Compares, one per kind of result
   task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask : chk_word
   task automatic chk_bit(input string n, input logic e, input logic g);
      chk_word(n, {15'h0000, e}, {15'h0000, g});
   endtask : chk_bit
   task automatic rd_chk(input logic [7:0] c, input logic [15:0] e, input string n);
      logic [15:0] q;
      i_ovfco_host.rd(c, q);
      chk_word(n, e, q);
   endtask : rd_chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   // One-cycle excursion of the sensed output above baseline
   task automatic ov_pulse(input int v);
      sense_pos = 12'(v);
      cyc(1);
      sense_pos = 12'd1100;
      cyc(2);
   endtask : ov_pulse
   task automatic complete_run();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, nvm_load, ss_done, fix_sel, fix_trip, en_pin} = 6'b001001;
      {iout, sense_pos, sense_gnd, vcmd} = {12'd0, 12'd1100, 12'd100, 12'd1000};
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      nvm_load = 1'b1;
      cyc(1);
      nvm_load = 1'b0;
      // Restored values and fixed fields
      rd_chk(ovfco_pkg::CMD_OFFSET, 16'hF7F9, "offset");
      rd_chk(ovfco_pkg::CMD_OV_LIMIT, 16'h0258, "limit");
      rd_chk(ovfco_pkg::CMD_OV_ACTION, 16'h00BF, "action");
      chk_bit("retry_store", 1'b1, retry_store);
      i_ovfco_host.wr(ovfco_pkg::CMD_OV_ACTION, 16'h0045);
      rd_chk(ovfco_pkg::CMD_OV_ACTION, 16'h0000, "action");
      chk_bit("retry_store", 1'b0, retry_store);
      i_ovfco_host.wr(ovfco_pkg::CMD_OV_ACTION, 16'h0090);
      chk_bit("invalid", 1'b1, invalid_data_r);
      rd_chk(ovfco_pkg::CMD_OV_ACTION, 16'h0000, "action");
      // Offset arithmetic and floor at zero
      for (int i = 0; i < 4; i++) begin
         i_ovfco_host.wr(ovfco_pkg::CMD_OFFSET, {12'h000, man[i]});
         iout = 12'(meas[i]);
         cyc(2);
         chk_word("iout", 16'(exp_i[i]), {4'h0, iout_rep});
      end
      i_ovfco_host.wr(ovfco_pkg::CMD_OV_LIMIT, 16'hFFFF);
      rd_chk(ovfco_pkg::CMD_OV_LIMIT, 16'h07FF, "limit");
      // Threshold bands at each boundary, fault ignored
      for (int i = 0; i < 6; i++) begin
         i_ovfco_host.wr(ovfco_pkg::CMD_OV_LIMIT, 16'(lim[i]));
         ov_pulse(1100 + 10 * pct[i]);
         chk_bit("at_limit", 1'b0, ovf);
         ov_pulse(1101 + 10 * pct[i]);
         chk_bit("over_limit", 1'b1, ovf);
         chk_bit("enable", 1'b1, oe);
         i_ovfco_host.clr();
      end
      // Pending fault acted on once response enabled, then latch-off
      i_ovfco_host.wr(ovfco_pkg::CMD_OV_LIMIT, 16'h0000);
      ov_pulse(2221);
      i_ovfco_host.wr(ovfco_pkg::CMD_OV_ACTION, 16'h0080);
      cyc(2);
      chk_bit("enable", 1'b0, oe);
      chk_bit("word_flag", 1'b1, output_fault_summary_flag);
      chk_bit("vout_flag", 1'b1, vst);
      chk_bit("alert_n", 1'b0, alert_n);
      i_ovfco_host.clr();
      cyc(3);
      chk_bit("flag", 1'b0, ovf);
      chk_bit("alert_n", 1'b1, alert_n);
      chk_bit("enable", 1'b0, oe);
      en_pin = 1'b0;
      cyc(1);
      en_pin = 1'b1;
      cyc(3);
      chk_bit("enable", 1'b1, oe);
      // No tracking fault during the ramp
      ss_done = 1'b0;
      sense_pos = 12'd2000;
      cyc(3);
      chk_bit("ramp", 1'b0, ovf);
      sense_pos = 12'd1100;
      ss_done = 1'b1;
      // Auto-restart, repeated, from the fixed threshold path
      i_ovfco_host.wr(ovfco_pkg::CMD_OV_ACTION, 16'h00B8);
      rd_chk(ovfco_pkg::CMD_OV_ACTION, 16'h00BF, "action");
      fix_trip = 1'b1;
      cyc(2);
      chk_bit("unselected", 1'b0, ovf);
      for (int k = 0; k < 2; k++) begin
         fix_sel = 1'b1;
         cyc(1);
         fix_sel = 1'b0;
         chk_bit("shutdown", 1'b0, oe);
         cyc(RC - 2);
         chk_bit("waiting", 1'b0, oe);
         cyc(2);
         chk_bit("idle", 1'b0, oe);
         cyc(1);
         chk_bit("restart", 1'b1, oe);
      end
      // Restore with the retry bit low spreads it to all three bits
      nvm_bit = 1'b0;
      nvm_load = 1'b1;
      cyc(1);
      nvm_load = 1'b0;
      rd_chk(ovfco_pkg::CMD_OV_ACTION, 16'h0080, "action");
      chk_bit("retry_store", 1'b0, retry_store);
      complete_run();
   end
endmodule : ovfco_top_bench
`default_nettype wire

// *** verilog/ovfco_top.sv ***
// Overvoltage fault response, fault threshold and current offset command logic.
// Assumes the command interface has already decoded bus framing into one-cycle
// read and write strobes, and that NVM restore arrives as a one-cycle load.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Add signed offset to reported output current
// - Clamp reported current at zero
// - Offset exponent fixed read-only at minus two
// - Bits 10:4 replicate mantissa bit 3
// - Four-bit two's complement writable mantissa
// - Compare sensed output against relative threshold
// - Tracking fault only after soft-start completes
// - Limit field 11 bits, upper bits zero
// - Limit decoded by range into percent
// - Fault sets three flags and alert
// - Response covers limit and fixed threshold
// - Bit 7 low ignores, high shuts down
// - Enabling response acts on uncleared earlier fault
// - Retry 000 latches off until enable toggle
// - Retry 111 restarts after 52 ms forever
// - Other retry values rejected as invalid data
// - Only retry bit 5 kept in NVM
// - Delay field mirrors retry, writes ignored
// - Delay 000 schedules no restart
// - Delay 111 waits 52 ms then starts
// - Action bit 6 always reads zero
// - Limit reads back as written, threshold decoded
module ovfco_top #(
   parameter int unsigned RESTART_CYC = ovfco_pkg::RESTART_CYC   // Shorten for simulation
) (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   // Command port
   input  wire logic                       cmd_wr,
   input  wire logic                       cmd_rd,
   input  wire logic [7:0]                 cmd_code,
   input  wire logic [15:0]                cmd_wdata,
   input  wire logic                       clear_faults,
   output logic      [15:0]                cmd_rdata_r,
   output logic                            cmd_rvalid_r,
   output logic                            invalid_data_r,
   // NVM restore and store
   input  wire logic                       nvm_load,
   input  wire logic [3:0]                 nvm_offset_mantissa,
   input  wire logic [10:0]                nvm_ov_limit,
   input  wire logic                       nvm_ov_act_not_ignore,
   input  wire logic                       nvm_ov_retry_bit,
   output logic                            nvm_ov_retry_store_r,
   // Current telemetry
   input  wire logic [ovfco_pkg::IOUT_W-1:0] iout_measured,
   output logic      [ovfco_pkg::IOUT_W-1:0] iout_report_r,
   // Voltage sensing and conversion control
   input  wire logic [ovfco_pkg::VOUT_W-1:0] output_sense_positive,
   input  wire logic [ovfco_pkg::VOUT_W-1:0] output_sense_ground,
   input  wire logic [ovfco_pkg::VOUT_W-1:0] vout_commanded,
   input  wire logic                       softstart_done,
   input  wire logic                       fixed_ov_threshold_select,
   input  wire logic                       fixed_ov_trip,
   input  wire logic                       en_pin,
   output logic                            output_enable_r,
   // Status
   output logic                            overvoltage_fault_flag_r,
   output logic                            output_fault_summary_flag_r,
   output logic                            vout_status_ov_flag_r,
   output logic                            smbalert_n_r
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   // One packed record holds every flip-flop; the
   // combinational block below fills a copy of it
   typedef struct packed {
      logic [3:0]                          offset_mantissa;  // Writable offset
      logic [10:0]                         ov_limit;         // Limit as written
      logic                                ov_act_not_ignore;// Response enable
      logic [2:0]                          ov_retry_select;  // Retry setting
      logic                                ov_pending;       // Fault seen while ignoring
      ovfco_pkg::ovfco_state_t             state;            // Response state
      logic [ovfco_pkg::DELAY_CNT_W-1:0]   delay_cnt;        // Restart timer
      logic                                en_seen_low;      // Enable toggle tracker
      logic [15:0]                         rdata;
      logic                                rvalid;
      logic                                invalid;
      logic [ovfco_pkg::IOUT_W-1:0]        iout;
      logic                                out_en;
      logic                                flag_byte;
      logic                                flag_word;
      logic                                flag_vout;
      logic                                alert_n;          // Alert pin level, low on fault
   } ovfco_regs_t;

   ovfco_regs_t r_r;    // Registered state
   ovfco_regs_t r_nxt;  // Next state

   // Restart delay in cycles less one, at the width of the timer
   localparam logic [ovfco_pkg::DELAY_CNT_W-1:0] DELAY_LAST =
      ovfco_pkg::DELAY_CNT_W'(RESTART_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Combinational helpers

   logic [ovfco_pkg::VOUT_W-1:0] vout_diff;      // Differential sense
   logic [7:0]                   ov_pct;         // Decoded threshold percent
   logic [19:0]                  sense_scaled;   // Sense times 100
   logic [19:0]                  limit_scaled;   // Command times (100 + pct)
   logic                         trip_tracking;  // Programmable limit exceeded
   logic                         ov_event;       // Any overvoltage this cycle
   logic signed [13:0]           iout_sum;       // Measured plus offset
   logic [2:0]                   wr_retry;       // Retry field being written

   // Differential sense, threshold decode and compare
   always_comb begin
      vout_diff = output_sense_positive - output_sense_ground;
      // Nearest supported setting; stored value untouched
      if (r_r.ov_limit < ovfco_pkg::LIMIT_BRK_16) begin
         ov_pct = ovfco_pkg::PCT_12;
      end else if (r_r.ov_limit < ovfco_pkg::LIMIT_BRK_20) begin
         ov_pct = ovfco_pkg::PCT_16;
      end else if (r_r.ov_limit < ovfco_pkg::LIMIT_BRK_50) begin
         ov_pct = ovfco_pkg::PCT_20;
      end else begin
         ov_pct = ovfco_pkg::PCT_50;
      end
      // Multiply instead of divide: sense*100 > cmd*(100+pct)
      sense_scaled  = 20'(vout_diff) * 20'(ovfco_pkg::PCT_FULL);
      limit_scaled  = 20'(vout_commanded) * 20'(ovfco_pkg::PCT_FULL + ov_pct);
      trip_tracking = softstart_done && (sense_scaled > limit_scaled);
      ov_event      = trip_tracking || (fixed_ov_threshold_select && fixed_ov_trip);
      // Signed sum of telemetry and sign-extended offset
      iout_sum = $signed({2'b00, iout_measured}) +
                 $signed({{10{r_r.offset_mantissa[3]}}, r_r.offset_mantissa});
      wr_retry = cmd_wdata[ovfco_pkg::ACT_RETRY_LSB +: 3];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      r_nxt        = r_r;
      r_nxt.rvalid = 1'b0;
      r_nxt.invalid = 1'b0;

      // Reported current, floored at zero
      if (iout_sum < 0) begin
         r_nxt.iout = '0;
      end else if (iout_sum[ovfco_pkg::IOUT_W]) begin
         r_nxt.iout = '1;                                                       // Saturate rather than wrap
      end else begin
         r_nxt.iout = iout_sum[ovfco_pkg::IOUT_W-1:0];
      end

      // Command writes; read-only fields have no storage
      if (cmd_wr) begin
         if (cmd_code == ovfco_pkg::CMD_OFFSET) begin
            r_nxt.offset_mantissa = cmd_wdata[3:0];
         end else if (cmd_code == ovfco_pkg::CMD_OV_LIMIT) begin
            r_nxt.ov_limit = cmd_wdata[10:0];
         end else if (cmd_code == ovfco_pkg::CMD_OV_ACTION) begin
            // Only the two legal retry codes are accepted
            if (wr_retry == ovfco_pkg::RETRY_LATCH || wr_retry == ovfco_pkg::RETRY_AUTO) begin
               r_nxt.ov_act_not_ignore = cmd_wdata[ovfco_pkg::ACT_IGNORE_BIT];
               r_nxt.ov_retry_select   = wr_retry;                              // Bits 2:0 dropped
            end else begin
               r_nxt.invalid = 1'b1;
            end
         end
      end

      // Only writable fields are restored; read-only fields
      // are rebuilt from them on every read
      // NVM restore wins over a same-cycle write
      if (nvm_load) begin
         r_nxt.offset_mantissa   = nvm_offset_mantissa;
         r_nxt.ov_limit          = nvm_ov_limit;
         r_nxt.ov_act_not_ignore = nvm_ov_act_not_ignore;
         r_nxt.ov_retry_select   = {3{nvm_ov_retry_bit}};
      end

      // Command reads
      if (cmd_rd) begin
         r_nxt.rvalid = 1'b1;
         if (cmd_code == ovfco_pkg::CMD_OFFSET) begin
            r_nxt.rdata = {ovfco_pkg::OFFSET_EXP,
                           {ovfco_pkg::OFFSET_EXT_W{r_r.offset_mantissa[3]}},
                           r_r.offset_mantissa};
         end else if (cmd_code == ovfco_pkg::CMD_OV_LIMIT) begin
            r_nxt.rdata = {5'h00, r_r.ov_limit};
         end else if (cmd_code == ovfco_pkg::CMD_OV_ACTION) begin
            r_nxt.rdata = {8'h00, r_r.ov_act_not_ignore, 1'b0,
                           r_r.ov_retry_select, r_r.ov_retry_select};
         end else begin
            r_nxt.rdata = 16'h0000;                                             // Unknown code
         end
      end

      // Status flags: clear first so a new fault wins
      // so a fault arriving with clear-faults is never lost
      if (clear_faults) begin
         r_nxt.flag_byte  = 1'b0;
         r_nxt.flag_word  = 1'b0;
         r_nxt.flag_vout  = 1'b0;
         r_nxt.ov_pending = 1'b0;
      end
      if (ov_event) begin
         r_nxt.flag_byte = 1'b1;
         r_nxt.flag_word = 1'b1;
         r_nxt.flag_vout = 1'b1;
         if (!r_r.ov_act_not_ignore) begin
            r_nxt.ov_pending = 1'b1;
         end
      end

      // Enable toggle tracking for restart from latch-off
      if (!en_pin) begin
         r_nxt.en_seen_low = 1'b1;
      end

      // Faults arriving while shut down only set flags;
      // the response is taken once, from RUN
      // Response state machine
      case (r_r.state)
         ovfco_pkg::OVFCO_RUN: begin
            // Respond to a fresh fault, or an uncleared one once enabled
            if (r_r.ov_act_not_ignore && (ov_event || r_r.ov_pending)) begin
               r_nxt.ov_pending  = 1'b0;
               r_nxt.en_seen_low = 1'b0;
               r_nxt.delay_cnt   = '0;
               if (r_r.ov_retry_select == ovfco_pkg::RETRY_AUTO) begin
                  r_nxt.state = ovfco_pkg::OVFCO_WAIT;
               end else begin
                  r_nxt.state = ovfco_pkg::OVFCO_LATCHED;
               end
            end
         end
         ovfco_pkg::OVFCO_LATCHED: begin
            // No timer; only an enable toggle brings it back
            if (r_r.en_seen_low && en_pin) begin
               r_nxt.state = ovfco_pkg::OVFCO_IDLE;
            end
         end
         ovfco_pkg::OVFCO_WAIT: begin
            // Retries forever: no attempt counter by design
            // Timer is wide enough for the full delay at 50 MHz
            if (r_r.delay_cnt == DELAY_LAST) begin
               r_nxt.state = ovfco_pkg::OVFCO_IDLE;
            end else begin
               r_nxt.delay_cnt = r_r.delay_cnt + 1'b1;
            end
         end
         ovfco_pkg::OVFCO_IDLE: begin
            // Normal startup handoff
            r_nxt.state = ovfco_pkg::OVFCO_RUN;
         end
         default: begin
            r_nxt.state = ovfco_pkg::OVFCO_RUN;
         end
      endcase

      // Conversion runs only in RUN with enable high
      r_nxt.out_en = (r_nxt.state == ovfco_pkg::OVFCO_RUN) && en_pin;

      // Alert pin follows the overvoltage fault flag
      r_nxt.alert_n = ~r_nxt.flag_byte;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; VCC power cycle maps to reset

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_r                   <= '0;
         r_r.ov_act_not_ignore <= ovfco_pkg::ACT_IGNORE_RST;
         r_r.state             <= ovfco_pkg::OVFCO_RUN;
         r_r.alert_n           <= 1'b1;                                         // Alert released
      end else begin
         r_r <= r_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, each a flip-flop
   // The alert has its own flop so no gate sits
   // between the register and the pin

   assign cmd_rdata_r                 = r_r.rdata;
   assign cmd_rvalid_r                = r_r.rvalid;
   assign invalid_data_r              = r_r.invalid;
   assign nvm_ov_retry_store_r        = r_r.ov_retry_select[2];
   assign iout_report_r               = r_r.iout;
   assign output_enable_r             = r_r.out_en;
   assign overvoltage_fault_flag_r    = r_r.flag_byte;
   assign output_fault_summary_flag_r = r_r.flag_word;
   assign vout_status_ov_flag_r       = r_r.flag_vout;
   assign smbalert_n_r                = r_r.alert_n;

endmodule : ovfco_top
`default_nettype wire
